// [ipf_core.sv]
// Purpose: four-phase instruction cycle, two-stage fetch/execute pipeline and 8-bit alu
// Assumes: memories answer within one phase; all inputs synchronous to i_mclk
// Notes:   the data memory commits a write when we is high and o_sys_tick pulses
`timescale 1ns/100ps
`default_nettype none

// Summary of operation
// - four non-overlapping phases form one instruction cycle
// - phase one increments pc and fetches next
// - phases two to four decode and execute
// - fetch overlaps execute, one instruction per cycle
// - pc-changing instructions take two cycles
// - first cycle gets target, second transfers control
// - 8-bit alu: arith, logic, rotate, inc, dec, branch
// - operands and results move via accumulator and alu
// - core registers mapped, direct and indirect access
// - system clock from one selected oscillator
// - taken skip discards prefetch, inserts dummy cycle
// - pc low byte write jumps in page, dummy
// - reset loads pc zero and fetches there
module ipf_core #(
	parameter int PC_W = ipf_pkg::PC_W,                  // program counter width
	parameter int DW   = ipf_pkg::DW                     // data path width
) (
	input  wire logic                 i_mclk,            // 200 MHz core clock
	input  wire logic                 i_resetn,          // async reset, active low
	input  wire logic [1:0]           i_osc_sel,         // oscillator source select
	input  wire logic                 i_ext_osc_tick,    // external crystal tick
	input  wire logic                 i_fast_rc_tick,    // fast internal rc tick
	input  wire logic                 i_slow_rc_tick,    // slow internal rc tick
	input  wire logic [15:0]          i_fetch_data,      // program word for fetch address
	input  wire logic [DW-1:0]        i_dm_rdata,        // data memory read data
	input  wire logic [PC_W-1:0]      i_pop_addr,        // return address from stack
	output logic                      o_sys_tick,        // selected system clock enable
	output logic [3:0]                o_phase,           // one-hot phase indication
	output ipf_pkg::ipf_fetch_t       o_fetch,           // program memory request
	output ipf_pkg::ipf_dmem_t        o_dmem,            // data memory request
	output logic                      o_push,            // push pulse on call commit
	output logic [PC_W-1:0]           o_push_addr,       // return address to push
	output logic                      o_pop,             // pop pulse on return commit
	output logic                      o_exec_valid,      // current cycle executes a real op
	output logic [DW-1:0]             o_acc,             // accumulator contents
	output logic [PC_W-1:0]           o_pc               // program counter contents
);
	logic [1:0]        ph_q;                             // phase counter
	logic [PC_W-1:0]   pc_q;                             // program counter
	logic [PC_W-1:0]   fetch_addr_q;                     // address of word being fetched
	logic [15:0]       prefetch_q;                       // prefetched instruction
	logic              prefetch_valid_q;                 // prefetch holds a real word
	logic [15:0]       ir_q;                             // instruction under execution
	logic              exec_valid_q;                     // ir holds a real, non-stale word
	logic [DW-1:0]     acc_q;                            // accumulator
	logic [DW-1:0]     ptr_q;                            // indirect memory pointer
	logic              carry_q;                          // carry flag
	logic              zero_q;                           // zero flag
	logic [DW-1:0]     result_q;                         // alu result held for commit
	logic              res_c_q;                          // carry of held result
	logic              skip_q;                           // skip condition met
	logic              wr_mem_q;                         // commit writes data memory
	logic              push_q;                           // push pulse register
	logic              pop_q;                            // pop pulse register
	logic              tick;                             // selected oscillator enable
	logic              cycle_end;                        // last tick of an instruction cycle
	logic              redirect;                         // control transfer at commit
	logic [PC_W-1:0]   target;                           // address for control transfer
	ipf_pkg::ipf_op_t  op;                               // decoded opcode
	logic              dst_mem;                          // destination is memory
	logic [DW-1:0]     maddr;                            // direct address field
	logic [DW-1:0]     ea;                               // effective address
	logic              ea_mapped;                        // effective address is a core register
	logic [DW-1:0]     mapped_rd;                        // core register read value
	logic [DW-1:0]     operand;                          // operand seen in read phase
	logic [DW:0]       alu;                              // carry and result

	// pick exactly one oscillator as system clock; unknown selects give no ticks
	always_comb begin
		unique case (i_osc_sel)
			2'(ipf_pkg::IPF_OSC_EXT):  tick = i_ext_osc_tick;
			2'(ipf_pkg::IPF_OSC_FAST): tick = i_fast_rc_tick;
			2'(ipf_pkg::IPF_OSC_SLOW): tick = i_slow_rc_tick;
			default:                   tick = 1'b0;             // reserved code stops core
		endcase
	end

	assign o_sys_tick = tick;
	assign cycle_end = tick && (ph_q == ipf_pkg::PH_WRITE);

	// phase generator; only one phase is ever active so they cannot overlap
	always_ff @(posedge i_mclk or negedge i_resetn) begin
		if (!i_resetn) begin
			ph_q <= ipf_pkg::PH_RESET;
		end else if (tick) begin
			ph_q <= ph_q + 2'h1;
		end
	end

	// one-hot phase view for the rest of the chip
	always_comb begin
		o_phase = 4'h0;
		o_phase[ph_q] = 1'b1;
	end

	// instruction field decode
	assign op = ipf_pkg::ipf_op_t'(ir_q[ipf_pkg::OP_MSB:ipf_pkg::OP_LSB]);
	assign dst_mem = ir_q[ipf_pkg::DST_BIT];
	assign maddr = ir_q[DW-1:0];

	// indirect slot redirects through the pointer; pointer to itself reads zero
	assign ea = (maddr == ipf_pkg::ADDR_IND) ? ptr_q : maddr;

	// core registers reachable at mapped addresses
	always_comb begin
		ea_mapped = 1'b1;
		unique case (ea)
			ipf_pkg::ADDR_IND:  mapped_rd = 8'h00;             // nested indirect reads zero
			ipf_pkg::ADDR_PTR:  mapped_rd = ptr_q;
			ipf_pkg::ADDR_ACC:  mapped_rd = acc_q;
			ipf_pkg::ADDR_PCL:  mapped_rd = pc_q[DW-1:0];
			ipf_pkg::ADDR_STAT: mapped_rd = {6'h00, carry_q, zero_q};
			default: begin
				ea_mapped = 1'b0;                        // ordinary data memory
				mapped_rd = 8'h00;
			end
		endcase
	end

	assign operand = ea_mapped ? mapped_rd : i_dm_rdata;

	// 8-bit alu; second operand from memory except the MOVI immediate, first from the accumulator
	always_comb begin
		unique case (op)
			ipf_pkg::IPF_OP_MOVI: alu = {1'b0, ir_q[DW-1:0]};
			ipf_pkg::IPF_OP_LDA:  alu = {1'b0, operand};
			ipf_pkg::IPF_OP_STA:  alu = {1'b0, acc_q};
			ipf_pkg::IPF_OP_ADD:  alu = {1'b0, acc_q} + {1'b0, operand};
			ipf_pkg::IPF_OP_SUB:  alu = {1'b0, operand} + {1'b0, ~acc_q} + 9'h001;
			ipf_pkg::IPF_OP_AND:  alu = {1'b0, acc_q & operand};
			ipf_pkg::IPF_OP_XOR:  alu = {1'b0, acc_q ^ operand};
			ipf_pkg::IPF_OP_RR:   alu = {operand[0], operand[0], operand[DW-1:1]};
			ipf_pkg::IPF_OP_RL:   alu = {operand[DW-1], operand[DW-2:0], operand[DW-1]};
			ipf_pkg::IPF_OP_INC:  alu = {1'b0, operand} + 9'h001;
			ipf_pkg::IPF_OP_DEC:  alu = {1'b0, operand} - 9'h001;
			ipf_pkg::IPF_OP_SZ:   alu = {1'b0, operand};                       // branch decision
			default:              alu = {1'b0, acc_q};                         // no data result
		endcase
	end

	// control transfers resolve at the end of the cycle that decoded them
	always_comb begin
		redirect = 1'b0;
		target = pc_q;
		if (exec_valid_q) begin
			unique case (op)
				ipf_pkg::IPF_OP_JMP, ipf_pkg::IPF_OP_CALL: begin
					redirect = 1'b1;
					target = ir_q[PC_W-1:0];
				end
				ipf_pkg::IPF_OP_RET: begin
					redirect = 1'b1;
					target = i_pop_addr;
				end
				ipf_pkg::IPF_OP_SZ: begin
					redirect = skip_q;
					target = pc_q;                       // refetch past the skipped word
				end
				default: begin
					if (wr_mem_q == 1'b0 && dst_mem && ea == ipf_pkg::ADDR_PCL
						&& op != ipf_pkg::IPF_OP_NOP && op != ipf_pkg::IPF_OP_MOVI
						&& op != ipf_pkg::IPF_OP_LDA) begin
						redirect = 1'b1;
						target = {pc_q[PC_W-1:DW], result_q};  // stay in current page
					end
				end
			endcase
		end
	end

	// program counter and fetch address move together at the start of the fetch phase
	always_ff @(posedge i_mclk or negedge i_resetn) begin
		if (!i_resetn) begin
			pc_q <= ipf_pkg::PC_RESET;
			fetch_addr_q <= ipf_pkg::PC_RESET;
		end else if (cycle_end) begin
			fetch_addr_q <= redirect ? target : pc_q;
			pc_q <= (redirect ? target : pc_q) + 11'h001;
		end
	end

	assign o_fetch.strobe = (ph_q == ipf_pkg::PH_FETCH);
	assign o_fetch.addr = fetch_addr_q;
	assign o_pc = pc_q;

	// prefetch register fills while the previous word executes
	always_ff @(posedge i_mclk or negedge i_resetn) begin
		if (!i_resetn) begin
			prefetch_q <= ipf_pkg::INSTR_RESET;
			prefetch_valid_q <= 1'b0;
		end else if (tick && ph_q == ipf_pkg::PH_FETCH) begin
			prefetch_q <= i_fetch_data;
			prefetch_valid_q <= 1'b1;
		end
	end

	// execute stage; a redirect marks the already-fetched word stale
	always_ff @(posedge i_mclk or negedge i_resetn) begin
		if (!i_resetn) begin
			ir_q <= ipf_pkg::INSTR_RESET;
			exec_valid_q <= 1'b0;                        // reset cycle executes nothing
		end else if (cycle_end) begin
			ir_q <= prefetch_q;
			exec_valid_q <= prefetch_valid_q && !redirect;
		end
	end

	assign o_exec_valid = exec_valid_q;

	// operand read and alu result captured at the end of the read phase
	always_ff @(posedge i_mclk or negedge i_resetn) begin
		if (!i_resetn) begin
			result_q <= 8'h00;
			res_c_q <= 1'b0;
			skip_q <= 1'b0;
			wr_mem_q <= 1'b0;
		end else if (tick && ph_q == ipf_pkg::PH_READ) begin
			result_q <= alu[DW-1:0];
			res_c_q <= alu[DW];
			skip_q <= (alu[DW-1:0] == 8'h00);
			wr_mem_q <= exec_valid_q && !ea_mapped && (op == ipf_pkg::IPF_OP_STA
				|| (dst_mem && op >= ipf_pkg::IPF_OP_ADD && op <= ipf_pkg::IPF_OP_DEC));
		end else if (cycle_end) begin
			wr_mem_q <= 1'b0;                            // write lasts one phase only
		end
	end

	// data memory port: read in decode, write in commit; dummy cycles do neither
	always_ff @(posedge i_mclk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_dmem <= '0;
		end else if (tick) begin
			o_dmem.rd <= exec_valid_q && ph_q == ipf_pkg::PH_FETCH;
			o_dmem.we <= ph_q == ipf_pkg::PH_READ && exec_valid_q && !ea_mapped
				&& (op == ipf_pkg::IPF_OP_STA
				|| (dst_mem && op >= ipf_pkg::IPF_OP_ADD && op <= ipf_pkg::IPF_OP_DEC));
			o_dmem.addr <= ea;
			o_dmem.wdata <= alu[DW-1:0];
		end
	end

	// core register commit at the last tick of the cycle
	always_ff @(posedge i_mclk or negedge i_resetn) begin
		if (!i_resetn) begin
			acc_q <= ipf_pkg::ACC_RESET;
			ptr_q <= ipf_pkg::PTR_RESET;
			carry_q <= 1'b0;
			zero_q <= 1'b0;
		end else if (cycle_end && exec_valid_q) begin
			unique case (op)
				ipf_pkg::IPF_OP_MOVI, ipf_pkg::IPF_OP_LDA: begin
					acc_q <= result_q;
				end
				ipf_pkg::IPF_OP_ADD, ipf_pkg::IPF_OP_SUB, ipf_pkg::IPF_OP_AND,
				ipf_pkg::IPF_OP_XOR, ipf_pkg::IPF_OP_RR, ipf_pkg::IPF_OP_RL,
				ipf_pkg::IPF_OP_INC, ipf_pkg::IPF_OP_DEC: begin
					zero_q <= (result_q == 8'h00);
					if (op == ipf_pkg::IPF_OP_ADD || op == ipf_pkg::IPF_OP_SUB
						|| op == ipf_pkg::IPF_OP_RR || op == ipf_pkg::IPF_OP_RL) begin
						carry_q <= res_c_q;
					end
					if (!dst_mem || ea == ipf_pkg::ADDR_ACC) begin
						acc_q <= result_q;
					end else if (ea == ipf_pkg::ADDR_PTR) begin
						ptr_q <= result_q;
					end else if (ea == ipf_pkg::ADDR_STAT) begin
						carry_q <= result_q[ipf_pkg::STAT_C_BIT];
						zero_q <= result_q[ipf_pkg::STAT_Z_BIT];
					end
				end
				ipf_pkg::IPF_OP_STA: begin
					if (ea == ipf_pkg::ADDR_PTR) begin
						ptr_q <= result_q;
					end else if (ea == ipf_pkg::ADDR_STAT) begin
						carry_q <= result_q[ipf_pkg::STAT_C_BIT];
						zero_q <= result_q[ipf_pkg::STAT_Z_BIT];
					end
				end
				default: begin
					acc_q <= acc_q;                      // control ops touch no data
				end
			endcase
		end
	end

	// stack handshake pulses, one mclk each, in the mclk right after the commit tick
	always_ff @(posedge i_mclk or negedge i_resetn) begin
		if (!i_resetn) begin
			push_q <= 1'b0;
			pop_q <= 1'b0;
			o_push_addr <= ipf_pkg::PC_RESET;
		end else begin
			push_q <= cycle_end && exec_valid_q && op == ipf_pkg::IPF_OP_CALL;
			pop_q <= cycle_end && exec_valid_q && op == ipf_pkg::IPF_OP_RET;
			if (cycle_end) begin
				o_push_addr <= fetch_addr_q;             // word fetched behind the call; pc is one further
			end
		end
	end

	assign o_push = push_q;
	assign o_pop = pop_q;
	assign o_acc = acc_q;
endmodule

`default_nettype wire

// [ipf_core_bench.sv]
// Purpose: self-checking bench for the fetch/execute core
// Assumes: bench plays program memory, data memory and a one-deep stack
// Notes:   inputs change at the falling edge; traces taken at fetch ticks
`timescale 1ns/100ps
`default_nettype none
module ipf_core_bench;
	logic                i_mclk = 1'b0;            // core clock
	logic                i_resetn = 1'b0;          // reset, active low
	logic [1:0]          i_osc_sel = 2'h0;         // source select
	logic                i_ext_osc_tick = 1'b0;    // every 2nd mclk
	logic                i_fast_rc_tick = 1'b0;    // every 3rd mclk
	logic                i_slow_rc_tick = 1'b0;    // every 5th mclk
	logic [15:0]         i_fetch_data = 16'h0000;  // program word
	logic [7:0]          i_dm_rdata = 8'h00;       // data word
	logic [10:0]         i_pop_addr = 11'h000;     // stack top
	logic                o_sys_tick;               // selected tick
	logic [3:0]          o_phase;                  // one-hot phase
	ipf_pkg::ipf_fetch_t o_fetch;                  // fetch request
	ipf_pkg::ipf_dmem_t  o_dmem;                   // data request
	logic                o_push;                   // push pulse
	logic [10:0]         o_push_addr;              // return address
	logic                o_pop;                    // pop pulse
	logic                o_exec_valid;             // real op flag
	logic [7:0]          o_acc;                    // accumulator
	logic [10:0]         o_pc;                     // program counter
	int                  n_fail = 0;               // mismatches
	int                  num_checks = 0;           // comparisons
	int                  tick_n = 0;               // mclk counter for ticks
	logic [15:0]         prog [64];                // program memory
	logic [7:0]          dmem [256];               // data memory
	logic [10:0]         stk_q = 11'h000;          // one-deep stack
	int                  n_pop = 0;                // return pulses seen
	logic [10:0]         tr_addr [$];              // fetch address per cycle
	logic                tr_val [$];               // exec flag per cycle

	ipf_core dut (.i_mclk(i_mclk), .i_resetn(i_resetn), .i_osc_sel(i_osc_sel),
		.i_ext_osc_tick(i_ext_osc_tick), .i_fast_rc_tick(i_fast_rc_tick),
		.i_slow_rc_tick(i_slow_rc_tick), .i_fetch_data(i_fetch_data), .i_dm_rdata(i_dm_rdata),
		.i_pop_addr(i_pop_addr), .o_sys_tick(o_sys_tick), .o_phase(o_phase), .o_fetch(o_fetch),
		.o_dmem(o_dmem), .o_push(o_push), .o_push_addr(o_push_addr), .o_pop(o_pop),
		.o_exec_valid(o_exec_valid), .o_acc(o_acc), .o_pc(o_pc));

	// 5 ns clock
	always #2.5 i_mclk = ~i_mclk;
	// tick sources and memory answers, all off the sampling edge
	always @(negedge i_mclk) begin
		tick_n <= tick_n + 1;
		i_ext_osc_tick <= (tick_n % 2) == 0;
		i_fast_rc_tick <= (tick_n % 3) == 0;
		i_slow_rc_tick <= (tick_n % 5) == 0;
		i_fetch_data <= prog[o_fetch.addr[5:0]];
		i_dm_rdata <= dmem[o_dmem.addr];
		i_pop_addr <= stk_q;
	end
	// memory commit, stack push and per-cycle trace
	always @(posedge i_mclk) begin
		if (o_dmem.we && o_sys_tick)
			dmem[o_dmem.addr] <= o_dmem.wdata;
		if (o_push)
			stk_q <= o_push_addr;
		if (o_pop)
			n_pop++;
		if (i_resetn && o_sys_tick && o_phase[0]) begin
			tr_addr.push_back(o_fetch.addr);
			tr_val.push_back(o_exec_valid);
		end
	end

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		num_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic finish_test();
		$display("checks %0d mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	// reset with fresh memories: skip, call, subtract to memory, pc-low jump and self loop
	task automatic do_reset();
		logic [15:0] pt [11] = '{16'h1012, 16'h4020, 16'h3021, 16'hC022, 16'h10FF, 16'hE010,
			16'h5820, 16'h100A, 16'h3806, 16'h1055, 16'hD00A};
		@(negedge i_mclk);
		i_resetn = 1'b0;
		foreach (prog[i]) prog[i] = 16'h0000;
		foreach (dmem[i]) dmem[i] = 8'h00;
		for (int i = 0; i < 11; i++) prog[i] = pt[i];
		prog[16] = 16'h3023;
		prog[17] = 16'hF000;
		dmem[8'h20] = 8'h05;
		dmem[8'h06] = 8'hA5;
		repeat (20) @(negedge i_mclk);
		check({5'h00, o_pc}, 16'h0000);
		check({12'h000, o_phase}, 16'h0008);
		check({8'h00, o_acc}, 16'h0000);
		check({15'h0000, o_exec_valid}, 16'h0000);
		tr_addr.delete();
		tr_val.delete();
		stk_q = 11'h000;
		n_pop = 0;
		i_resetn = 1'b1;
	endtask

	// fetch order and dummy cycles, then the state left behind
	task automatic run_program();
		logic [10:0] ea [19] = '{11'h000, 11'h001, 11'h002, 11'h003, 11'h004, 11'h005, 11'h006,
			11'h010, 11'h011, 11'h012, 11'h006, 11'h007, 11'h008, 11'h009, 11'h00A, 11'h00B,
			11'h00A, 11'h00B, 11'h00A};
		logic [18:0] ev = 19'b0101011101101011110;
		for (int k = 0; k < 600 && tr_addr.size() < 19; k++) @(posedge i_mclk);
		check(16'(tr_addr.size() >= 19), 16'h0001);
		for (int i = 0; i < 19 && i < tr_addr.size(); i++) begin
			check({5'h00, tr_addr[i]}, {5'h00, ea[i]});
			check({15'h0000, tr_val[i]}, {15'h0000, ev[i]});
		end
		check({8'h00, dmem[8'h21]}, 16'h0017);
		check({8'h00, dmem[8'h23]}, 16'h0017);
		check({8'h00, dmem[8'h06]}, 16'h00A5);
		check({8'h00, dmem[8'h20]}, 16'h00EE);
		check({8'h00, o_acc}, 16'h000A);
		check({5'h00, stk_q}, 16'h0006);
		check(16'(n_pop), 16'h0001);
	endtask

	// each source alone drives the tick; code 3 freezes the core
	task automatic test_osc();
		int cnt;
		logic [3:0] ph;
		int exp_n [4] = '{30, 20, 12, 0};
		for (int s = 0; s < 4; s++) begin
			@(negedge i_mclk);
			i_osc_sel = 2'(s);
			@(negedge i_mclk);
			cnt = 0;
			ph = o_phase;
			repeat (60) begin
				@(posedge i_mclk);
				cnt += int'(o_sys_tick === 1'b1);
			end
			check(16'(cnt), 16'(exp_n[s]));
			if (s == 3)
				check({12'h000, o_phase}, {12'h000, ph});
		end
		@(negedge i_mclk);
		i_osc_sel = 2'h0;
	endtask

	// main sequence, with a second reset mid-run
	initial begin
		do_reset();
		run_program();
		test_osc();
		do_reset();
		run_program();
		finish_test();
	end
	// watchdog, about seven times the expected run
	initial begin
		#20000;
		n_fail++;
		finish_test();
	end
endmodule
`default_nettype wire

// [ipf_core_chk.sv]
// Purpose: timing relations of the four-phase fetch/execute core at its ports
// Assumes: one clock domain, async active-low reset
// Notes:   attached to every ipf_core instance by the bind below
`timescale 1ns/100ps
`default_nettype none
module ipf_core_chk #(
	parameter int PC_W = 11,                    // program counter width
	parameter int DW   = 8                      // data path width
) (
	input  wire logic                i_mclk,         // core clock
	input  wire logic                i_resetn,       // reset, active low
	input  wire logic [1:0]          i_osc_sel,      // source select
	input  wire logic                i_ext_osc_tick, // crystal tick
	input  wire logic                i_fast_rc_tick, // fast rc tick
	input  wire logic                i_slow_rc_tick, // slow rc tick
	input  wire logic                o_sys_tick,     // selected tick
	input  wire logic [3:0]          o_phase,        // one-hot phase
	input  wire ipf_pkg::ipf_fetch_t o_fetch,        // fetch request
	input  wire ipf_pkg::ipf_dmem_t  o_dmem,         // data request
	input  wire logic                o_exec_valid,   // real op this cycle
	input  wire logic                o_push,         // push pulse
	input  wire logic                o_pop,          // pop pulse
	input  wire logic [DW-1:0]       o_acc,          // accumulator
	input  wire logic [PC_W-1:0]     o_pc            // program counter
);
	logic [3:0] ph_rot;                         // phase one step on
	assign ph_rot = {o_phase[2:0], o_phase[3]};
	default clocking @(posedge i_mclk); endclocking
	default disable iff (!i_resetn);
	// phases never overlap
	phase_onehot_a: assert property ($onehot(o_phase))
		else $error("phase not one-hot");
	phase_hold_a: assert property (!o_sys_tick |=> $stable(o_phase))
		else $error("phase moved without tick");
	phase_step_a: assert property (o_sys_tick |=> o_phase == $past(ph_rot))
		else $error("phase did not step in order");
	// fetch belongs to the first phase, pc already past the fetch address
	fetch_strobe_a: assert property (o_fetch.strobe == o_phase[0])
		else $error("fetch strobe outside fetch phase");
	pc_ahead_a: assert property (o_phase[0] |-> o_pc == PC_W'(o_fetch.addr + 1'b1))
		else $error("pc not one past fetch address");
	rd_phase_a: assert property (o_dmem.rd |-> o_phase[1])
		else $error("data read outside decode phase");
	we_phase_a: assert property (o_dmem.we |-> o_phase[3])
		else $error("data write outside commit phase");
	// accumulator only moves on the commit tick
	acc_commit_a: assert property (!(o_sys_tick && o_phase[3]) |=> $stable(o_acc))
		else $error("accumulator changed off commit");
	dummy_quiet_a: assert property (!o_exec_valid |-> !o_dmem.rd && !o_dmem.we)
		else $error("dummy cycle touched memory");
	sel_source_a: assert property (o_sys_tick == ((i_osc_sel == 2'h0 && i_ext_osc_tick)
		|| (i_osc_sel == 2'h1 && i_fast_rc_tick) || (i_osc_sel == 2'h2 && i_slow_rc_tick)))
		else $error("system tick from wrong source");
	// stack pulses only right after the commit tick of a real instruction
	stack_pulse_a: assert property ((o_push || o_pop) |-> $past(o_sys_tick && o_phase[3] && o_exec_valid))
		else $error("stack pulse outside a real commit");
endmodule
bind ipf_core ipf_core_chk #(.PC_W(PC_W), .DW(DW)) u_chk (.i_mclk(i_mclk), .i_resetn(i_resetn),
	.i_osc_sel(i_osc_sel), .i_ext_osc_tick(i_ext_osc_tick), .i_fast_rc_tick(i_fast_rc_tick),
	.i_slow_rc_tick(i_slow_rc_tick), .o_sys_tick(o_sys_tick), .o_phase(o_phase),
	.o_fetch(o_fetch), .o_dmem(o_dmem), .o_exec_valid(o_exec_valid), .o_push(o_push),
	.o_pop(o_pop), .o_acc(o_acc), .o_pc(o_pc));
`default_nettype wire

// [ipf_pkg.sv]
// Purpose: shared constants, enums and carriers for the fetch/execute pipeline core
// Assumes: one 200 MHz clock; oscillator sources arrive as one-cycle tick enables
// Notes:   instruction word is a compact 16-bit encoding private to this core
package ipf_pkg;
	localparam int PC_W = 11;                            // program counter width
	localparam int IW = 16;                              // instruction word width
	localparam int DW = 8;                               // alu and data path width
	localparam int AW = 8;                               // data memory address width
	localparam int PH_W = 2;                             // phase counter width
	localparam int PH_N = 4;                             // phases per instruction cycle
	localparam logic [PH_W-1:0] PH_FETCH = 2'h0;         // phase_one_fetch
	localparam logic [PH_W-1:0] PH_DECODE = 2'h1;        // first of phases_decode_execute
	localparam logic [PH_W-1:0] PH_READ = 2'h2;          // operand read and alu
	localparam logic [PH_W-1:0] PH_WRITE = 2'h3;         // commit and write back
	localparam logic [PH_W-1:0] PH_RESET = 2'h3;         // first tick enters the fetch phase
	localparam logic [PC_W-1:0] PC_RESET = 11'h000;      // reset vector
	localparam logic [DW-1:0] ACC_RESET = 8'h00;         // accumulator after reset
	localparam logic [AW-1:0] PTR_RESET = 8'h00;         // memory pointer after reset
	localparam logic [IW-1:0] INSTR_RESET = 16'h0000;    // no-op word
	// mapped core registers in data memory
	localparam logic [AW-1:0] ADDR_IND = 8'h00;          // indirect access through pointer
	localparam logic [AW-1:0] ADDR_PTR = 8'h01;          // memory pointer
	localparam logic [AW-1:0] ADDR_ACC = 8'h05;          // accumulator_reg
	localparam logic [AW-1:0] ADDR_PCL = 8'h06;          // pc_low_byte
	localparam logic [AW-1:0] ADDR_STAT = 8'h0A;         // status flags
	// instruction fields
	localparam int OP_MSB = 15;                          // opcode top bit
	localparam int OP_LSB = 12;                          // opcode bottom bit
	localparam int DST_BIT = 11;                         // 1: result to memory, 0: to accumulator
	localparam int STAT_C_BIT = 1;                       // carry position in status
	localparam int STAT_Z_BIT = 0;                       // zero position in status
	// oscillator source select
	typedef enum logic [1:0] {
		IPF_OSC_EXT,                                     // external_crystal_osc
		IPF_OSC_FAST,                                    // fast_internal_rc_osc
		IPF_OSC_SLOW                                     // slow_internal_rc_osc
	} ipf_osc_t;
	// opcodes, all sixteen codes used
	typedef enum logic [3:0] {
		IPF_OP_NOP, IPF_OP_MOVI, IPF_OP_LDA, IPF_OP_STA,
		IPF_OP_ADD, IPF_OP_SUB, IPF_OP_AND, IPF_OP_XOR,
		IPF_OP_RR, IPF_OP_RL, IPF_OP_INC, IPF_OP_DEC,
		IPF_OP_SZ, IPF_OP_JMP, IPF_OP_CALL, IPF_OP_RET
	} ipf_op_t;
	// program memory request
	typedef struct packed {
		logic            strobe;                         // high through the fetch phase
		logic [PC_W-1:0] addr;                           // word address being fetched
	} ipf_fetch_t;
	// data memory request
	typedef struct packed {
		logic          rd;                               // read through decode phase
		logic          we;                               // write through commit phase
		logic [AW-1:0] addr;                             // effective address
		logic [DW-1:0] wdata;                            // write data
	} ipf_dmem_t;
endpackage
